// >>> utb_defines.vh
// Register selectors, field positions and reset values for the trace control block
`ifndef UTB_DEFINES_VH
`define UTB_DEFINES_VH
// ==================================================
// Register selectors on the coprocessor move port
`define UTB_SEL_WORD_ONE   2'h0
`define UTB_SEL_WORD_TWO   2'h1
`define UTB_SEL_BKPT_CTL   2'h2
// ==================================================
// Breakpoint trace-control fields
`define UTB_DE_BIT         31
`define UTB_DACT_HI        17
`define UTB_DACT_LO        16
`define UTB_IE_BIT         15
`define UTB_IACT_HI        5
`define UTB_IACT_LO        0
`define UTB_CTL_WMASK      32'h8003803F
// ==================================================
// Reset values and record types
`define UTB_WORD_RESET     32'h00000000
`define UTB_CTL_RESET      32'h00000000
`define UTB_REC_TYPE_ONE   2'h1
`define UTB_REC_TYPE_TWO   2'h2
`endif

// >>> utb_skid_buffer.v
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module utb_skid_buffer #(
   parameter WIDTH = 34
) (
   // Clock and reset
   input  wire             clk,
   input  wire             reset,
   // Fill side
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   // Drain side
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem0;
   reg [WIDTH-1:0] mem1;
   reg [1:0]       count;
   wire            push;
   wire            pop;
   assign in_ready  = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data  = mem0;
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   always @(posedge clk)
   begin
      if (reset)
      begin
         count <= 2'h0;
         mem0  <= {WIDTH{1'h0}};
         mem1  <= {WIDTH{1'h0}};
      end
      else
      begin
         // Head shifts forward on pop; new word lands behind survivors
         if (pop)
            mem0 <= (count == 2'h2) ? mem1 : in_data;
         if (push)
         begin
            if ((count == 2'h0) || ((count == 2'h1) && pop))
               mem0 <= in_data;
            else if ((count == 2'h1) || ((count == 2'h2) && pop))
               mem1 <= in_data;
         end
         count <= count + {1'h0, push} - {1'h0, pop};
      end
   end
endmodule // utb_skid_buffer
`default_nettype wire

// >>> utb_trace_ctl.v
// User trace words and breakpoint trace-on/off control
`timescale 1ns/10ps
`default_nettype none
`include "utb_defines.vh"
// Functional notes
// - Writing word one emits a type 1 user record, word two a type 2 record.
// - Each user word is 32-bit read/write, resets to zero, and its record carries all 32 bits.
// - The user words exist only when instruction-flow trace is configured.
// - Breakpoint triggers can start and stop tracing, independent of debug exceptions.
// - The control register exists only with both breakpoints and trace configured.
// - Bit 31 enables data breakpoint triggers into trace, reset 0.
// - Bit 15 enables instruction breakpoint triggers into trace, reset 0.
// - Bits 17:16 are per data breakpoint actions, bit 16 the first.
// - An enabled data trigger with action 1 turns tracing on.
// - An enabled trigger with action 0 turns tracing off.
// - Action bits of absent breakpoints have no effect.
// - Bits 5:0 are per instruction breakpoint actions, bit 0 the first.
module utb_trace_ctl #(
   parameter HAS_USER_TRACE = 1,
   parameter HAS_BKPT_TRACE = 1,
   parameter NUM_IBKPT      = 6,
   parameter NUM_DBKPT      = 2
) (
   // Clock and reset
   input  wire        clk,
   input  wire        reset,
   // Coprocessor move port
   input  wire        cop_wr,
   input  wire [1:0]  cop_sel,
   input  wire [31:0] cop_wdata,
   output reg  [31:0] cop_rdata,
   // Breakpoint triggers, one-cycle pulses
   input  wire [5:0]  instr_bkpt_hit,
   input  wire [1:0]  data_bkpt_hit,
   // Trace record stream
   output wire        rec_valid,
   input  wire        rec_ready,
   output wire [1:0]  rec_type,
   output wire [31:0] rec_data,
   output wire        rec_overflow,
   // Trace on/off requests
   output reg         trace_on_req,
   output reg         trace_off_req
);
   // ==================================================
   // Registers
   reg  [31:0] user_trace_word_one;
   reg  [31:0] user_trace_word_two;
   reg  [31:0] breakpoint_trace_control;
   reg         overflow;
   reg         rec_push;
   reg  [33:0] rec_word;
   // Decoded strobes, fields and gated hits
   wire        push_ready;
   wire        wr_one;
   wire        wr_two;
   wire        wr_ctl;
   wire        data_bkpt_trigger_enable;
   wire        instr_bkpt_trigger_enable;
   wire [1:0]  data_bkpt_trace_action;
   wire [5:0]  instr_bkpt_trace_action;
   wire [5:0]  imask;
   wire [1:0]  dmask;
   wire [5:0]  ihit;
   wire [1:0]  dhit;
   wire        next_on;
   wire        next_off;

   // ==================================================
   // Decode helpers
   // Selector compare, shared by the three write strobes
   function sel_match;
      input [1:0] sel;
      input [1:0] code;
      begin
         sel_match = (sel == code);
      end
   endfunction

   // Gated hits whose action bit equals the wanted polarity
   function trig_match;
      input [5:0] ihits;
      input [1:0] dhits;
      input [5:0] iact;
      input [1:0] dact;
      input       want_on;
      begin
         if (want_on)
            trig_match = |(ihits & iact) | |(dhits & dact);
         else
            trig_match = |(ihits & ~iact) | |(dhits & ~dact);
      end
   endfunction

   assign wr_one = cop_wr & sel_match(cop_sel, `UTB_SEL_WORD_ONE) & (HAS_USER_TRACE != 0);
   assign wr_two = cop_wr & sel_match(cop_sel, `UTB_SEL_WORD_TWO) & (HAS_USER_TRACE != 0);
   assign wr_ctl = cop_wr & sel_match(cop_sel, `UTB_SEL_BKPT_CTL) & (HAS_BKPT_TRACE != 0);

   // ==================================================
   // User trace words
   always @(posedge clk)
   begin
      if (reset)
      begin
         user_trace_word_one <= `UTB_WORD_RESET;
         user_trace_word_two <= `UTB_WORD_RESET;
         rec_push            <= 1'h0;
         rec_word            <= 34'h000000000;
         overflow            <= 1'h0;
      end
      else
      begin
         if (wr_one)
            user_trace_word_one <= cop_wdata;
         if (wr_two)
            user_trace_word_two <= cop_wdata;
         // Registered push keeps the write path short
         // record type per word
         rec_push <= wr_one | wr_two;
         if (wr_one)
            rec_word <= {`UTB_REC_TYPE_ONE, cop_wdata};
         else if (wr_two)
            rec_word <= {`UTB_REC_TYPE_TWO, cop_wdata};
         // Sticky: a record dropped because the buffer was full
         // Cleared only by reset so a single loss stays visible
         if (rec_push & ~push_ready)
            overflow <= 1'h1;
      end
   end
   assign rec_overflow = overflow;

   // Buffer absorbs receiver stalls; back-to-back writes stay software's problem
   utb_skid_buffer #(
      .WIDTH(34)
   ) u_buf (
      .clk       (clk),
      .reset     (reset),
      .in_valid  (rec_push),
      .in_ready  (push_ready),
      .in_data   (rec_word),
      .out_valid (rec_valid),
      .out_ready (rec_ready),
      .out_data  ({rec_type, rec_data})
   );

   // ==================================================
   // Breakpoint trace control
   // Plain register; the trigger gates read it directly
   always @(posedge clk)
   begin
      if (reset)
         breakpoint_trace_control <= `UTB_CTL_RESET;
      else if (wr_ctl)
         breakpoint_trace_control <= cop_wdata & `UTB_CTL_WMASK;
   end

   assign data_bkpt_trigger_enable  = breakpoint_trace_control[`UTB_DE_BIT];
   assign instr_bkpt_trigger_enable = breakpoint_trace_control[`UTB_IE_BIT];
   assign data_bkpt_trace_action    = breakpoint_trace_control[`UTB_DACT_HI:`UTB_DACT_LO];
   assign instr_bkpt_trace_action   = breakpoint_trace_control[`UTB_IACT_HI:`UTB_IACT_LO];

   // Constant masks; absent triggers never reach the decode
   // absent breakpoints masked
   genvar g;
   generate
      for (g = 0; g < 6; g = g + 1)
      begin : g_imask
         assign imask[g] = (g < NUM_IBKPT) ? 1'h1 : 1'h0;
      end
      for (g = 0; g < 2; g = g + 1)
      begin : g_dmask
         assign dmask[g] = (g < NUM_DBKPT) ? 1'h1 : 1'h0;
      end
   endgenerate

   assign ihit = instr_bkpt_hit & imask & {6{instr_bkpt_trigger_enable}};
   assign dhit = data_bkpt_hit & dmask & {2{data_bkpt_trigger_enable}};
   assign next_on  = trig_match(ihit, dhit, instr_bkpt_trace_action,
                                data_bkpt_trace_action, 1'h1);
   assign next_off = trig_match(ihit, dhit, instr_bkpt_trace_action,
                                data_bkpt_trace_action, 1'h0);

   // Hits registered so on and off leave as clean pulses
   // Mixed hits may pulse both; the trace block arbitrates
   always @(posedge clk)
   begin
      if (reset)
      begin
         trace_on_req  <= 1'h0;
         trace_off_req <= 1'h0;
      end
      else
      begin
         trace_on_req  <= next_on;
         trace_off_req <= next_off;
      end
   end

   // ==================================================
   // Read mux
   // Absent registers read zero so software can probe the build
   always @*
   begin
      case (cop_sel)
         `UTB_SEL_WORD_ONE: cop_rdata = (HAS_USER_TRACE != 0) ? user_trace_word_one : 32'h0;
         `UTB_SEL_WORD_TWO: cop_rdata = (HAS_USER_TRACE != 0) ? user_trace_word_two : 32'h0;
         `UTB_SEL_BKPT_CTL: cop_rdata = (HAS_BKPT_TRACE != 0) ? breakpoint_trace_control : 32'h0;
         default:           cop_rdata = 32'h00000000;
      endcase
   end
endmodule // utb_trace_ctl
`default_nettype wire

// >>> utb_trace_ctl_asserts.sv
// Assertion checker for the user trace and breakpoint trace block
`timescale 1ns/10ps
`default_nettype none
module utb_trace_ctl_asserts (
   // Clock and reset
   input wire logic        clk,
   input wire logic        reset,
   // Register port
   input wire logic        cop_wr,
   input wire logic [1:0]  cop_sel,
   input wire logic [31:0] cop_wdata,
   input wire logic [31:0] cop_rdata,
   // Triggers and outputs
   input wire logic [5:0]  instr_bkpt_hit,
   input wire logic [1:0]  data_bkpt_hit,
   input wire logic        rec_valid,
   input wire logic        rec_ready,
   input wire logic [1:0]  rec_type,
   input wire logic [31:0] rec_data,
   input wire logic        rec_overflow,
   input wire logic        trace_on_req,
   input wire logic        trace_off_req
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Shadow control register, reserved bits masked off
   logic [31:0] ctl;
   always @(posedge clk)
      ctl <= reset ? 32'h0 : (cop_wr && cop_sel == 2'h2) ? cop_wdata & 32'h8003803F : ctl;
   // ==================================================
   // Properties
   a_word_one_rec: assert property (
      cop_wr && cop_sel == 2'h0 && !rec_valid && !$past(cop_wr) && !$past(cop_wr, 2)
      |-> ##2 rec_valid && rec_type == 2'h1 && rec_data == $past(cop_wdata, 2))
      else $error("word one record wrong");
   a_word_two_rec: assert property (
      cop_wr && cop_sel == 2'h1 && !rec_valid && !$past(cop_wr) && !$past(cop_wr, 2)
      |-> ##2 rec_valid && rec_type == 2'h2 && rec_data == $past(cop_wdata, 2))
      else $error("word two record wrong");
   a_ctl_readback: assert property (cop_sel == 2'h2 |-> cop_rdata == ctl)
      else $error("control readback wrong");
   a_reserved_zero: assert property (cop_sel == 2'h2 |-> !(cop_rdata & 32'h7FFC7FC0))
      else $error("reserved bits set");
   a_reset_clear: assert property ($past(reset) |-> !cop_rdata && !rec_valid
      && !trace_on_req && !trace_off_req) else $error("not clear after reset");
   a_rec_hold: assert property (rec_valid && !rec_ready
      |=> rec_valid && $stable({rec_type, rec_data})) else $error("record lost");
   a_data_on: assert property (ctl[31] && |(data_bkpt_hit & ctl[17:16]) |=> trace_on_req)
      else $error("data trigger gave no on");
   a_instr_on: assert property (ctl[15] && |(instr_bkpt_hit & ctl[5:0]) |=> trace_on_req)
      else $error("instr trigger gave no on");
   a_trig_off: assert property (ctl[31] && |(data_bkpt_hit & ~ctl[17:16])
      || ctl[15] && |(instr_bkpt_hit & ~ctl[5:0]) |=> trace_off_req) else $error("no off");
   a_gate_block: assert property (!(ctl[31] && |data_bkpt_hit)
      && !(ctl[15] && |instr_bkpt_hit) |=> !trace_on_req && !trace_off_req)
      else $error("blocked trigger passed");
   c_on: cover property (trace_on_req);
   c_off: cover property (trace_off_req);
   c_stall: cover property (rec_valid && !rec_ready ##1 rec_overflow);
endmodule // utb_trace_ctl_asserts
bind utb_trace_ctl utb_trace_ctl_asserts utb_trace_ctl_asserts_inst (.*);
`default_nettype wire

// >>> utb_trace_sink.sv
// Trace record receiver model with random back-pressure
`timescale 1ns/10ps
`default_nettype none
module utb_trace_sink (
   input  wire logic clk,
   input  wire logic stall,
   output var logic  rec_ready
);
   // Random takes so the buffer sees prompt and slow receivers
   initial rec_ready = 1'b0;
   always @(negedge clk)
      rec_ready <= !stall && ($urandom_range(3) != 0);
endmodule // utb_trace_sink
`default_nettype wire

// >>> utb_tb.sv
// Self-checking testbench for the trace control block
`timescale 1ns/10ps
`default_nettype none
`include "utb_defines.vh"
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin err_total++; \
   $display("MISMATCH %s exp %h got %h", n, e, a); end end
module testbench;
   logic clk = 0, reset = 1, cop_wr = 0, stall = 0, rec_valid, rec_ready, rec_overflow;
   logic trace_on_req, trace_off_req, on, off;
   logic [1:0] cop_sel = 0, data_bkpt_hit = 0, rec_type;
   logic [5:0] instr_bkpt_hit = 0;
   logic [31:0] cop_wdata = 0, cop_rdata, rec_data, r;
   logic [33:0] exp_q[$], e;
   int err_total = 0, check_count = 0, cyc = 0;
   always #5 clk = ~clk;
   utb_trace_ctl utb_trace_ctl_inst (.clk(clk), .reset(reset), .cop_wr(cop_wr),
      .cop_sel(cop_sel), .cop_wdata(cop_wdata), .cop_rdata(cop_rdata),
      .instr_bkpt_hit(instr_bkpt_hit), .data_bkpt_hit(data_bkpt_hit),
      .rec_valid(rec_valid), .rec_ready(rec_ready), .rec_type(rec_type),
      .rec_data(rec_data), .rec_overflow(rec_overflow),
      .trace_on_req(trace_on_req), .trace_off_req(trace_off_req));
   utb_trace_sink utb_trace_sink_inst (.clk(clk), .stall(stall), .rec_ready(rec_ready));
   task tally_and_finish;
      $display("errors %0d checks %0d", err_total, check_count);
      if (err_total == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // writes kept two cycles apart; user words note a record
   task wu(input [1:0] s, input [31:0] d);
      @(negedge clk);
      cop_wr = 1; cop_sel = s; cop_wdata = d;
      @(negedge clk);
      cop_wr = 0;
      if (s < 2'h2) exp_q.push_back({s + 2'h1, d});
   endtask
   task rd(input [1:0] s, input [31:0] d);
      @(negedge clk);
      cop_sel = s;
      #1 `CHK("rdata", d, cop_rdata)
   endtask
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         err_total++;
         tally_and_finish;
      end
      else if (!reset && rec_valid && rec_ready)
      begin
         e = exp_q.pop_front();
         `CHK("record", e, {rec_type, rec_data})
      end
   end
   initial
   begin
      r = $urandom(43097);
      repeat (6) @(negedge clk);
      reset = 0;
      for (int s = 0; s < 4; s++) rd(2'(s), 32'h0);
      wu(2'h3, 32'hFFFFFFFF);
      rd(2'h3, 32'h0);
      // Stall the receiver so the third record overflows
      stall = 1;
      repeat (2) @(negedge clk);
      wu(2'h0, 32'hA5A5A5A5);
      wu(2'h1, 32'h5A5A5A5A);
      wu(2'h0, 32'h0F0F0F0F);
      e = exp_q.pop_back();
      @(negedge clk) `CHK("overflow", 1'b1, rec_overflow)
      stall = 0;
      for (int i = 0; i < 12; i++)
      begin
         r = $urandom;
         wu({1'b0, r[0]}, r);
         rd({1'b0, r[0]}, r);
      end
      for (int i = 0; i < 40; i++)
      begin
         r = $urandom;
         wu(2'h2, r);
         r = r & `UTB_CTL_WMASK;
         @(negedge clk);
         {instr_bkpt_hit, data_bkpt_hit} = 8'($urandom);
         on = r[31] && |(data_bkpt_hit & r[17:16]) || r[15] && |(instr_bkpt_hit & r[5:0]);
         off = r[31] && |(data_bkpt_hit & ~r[17:16]) || r[15] && |(instr_bkpt_hit & ~r[5:0]);
         @(negedge clk);
         {instr_bkpt_hit, data_bkpt_hit} = 0;
         `CHK("on", on, trace_on_req)
         `CHK("off", off, trace_off_req)
         rd(2'h2, r);
      end
      repeat (20) @(negedge clk);
      `CHK("left", 0, exp_q.size())
      tally_and_finish;
   end
endmodule // testbench
`default_nettype wire
